// *** tcw_timer_capture_select_watchdog.sv ***
// Purpose: APB register file for capture source select and digital watchdog
// Assumes: All inputs synchronous to ref_clk; tmr_tick is the timer clock
// Notes: Read data is captured in the setup cycle, so pready is low only while ce is low
`timescale 1ns/10ps
`default_nettype none
module tcw_timer_capture_select_watchdog import tcw_pkg::*; #(
  parameter int CNT_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_EVT-1:0] dma_evt,
  input wire logic tmr_tick,
  input wire tcw_cap_s cnt0_now,
  input wire tcw_cap_s cnt1_now,
  input wire logic analog_wd_flag,
  output logic wd_reset_req,
  output logic irq
);

  typedef struct packed {
    logic [SEL_W-1:0] sel0;
    logic [SEL_W-1:0] sel1;
    logic [CNT_W-1:0] preload;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [31:0] rdata;
    logic slverr;
  } tcw_regs_s;

  tcw_regs_s st_reg;
  tcw_regs_s st_next;

  logic setup_ph;
  logic wr_acc;
  logic cap0_pulse;
  logic cap1_pulse;
  logic wd_exp_pulse;
  logic wd_enabled;
  logic wd_expired;
  logic [CNT_W-1:0] wd_count;
  tcw_cap_s cap0;
  tcw_cap_s cap1;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0] rd_val;
  logic rd_hit;

  // Zero-extend a narrow field into a bus word
  function automatic logic [31:0] zext3(input logic [2:0] v);
    zext3 = {29'h0, v};
  endfunction

  // Address match for a register
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  assign setup_ph = ce & psel & ~penable;
  assign wr_acc = ce & psel & penable & pwrite;
  // Ready drops with ce so a frozen block never completes a transfer
  assign pready = ce;

  tcw_capture_sel #(
    .N_EVT(NUM_EVT)
  ) u_cap0 (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .dma_evt(dma_evt),
    .sel(st_reg.sel0),
    .now_cnt(cnt0_now),
    .cap(cap0),
    .cap_pulse(cap0_pulse)
  );

  tcw_capture_sel #(
    .N_EVT(NUM_EVT)
  ) u_cap1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .dma_evt(dma_evt),
    .sel(st_reg.sel1),
    .now_cnt(cnt1_now),
    .cap(cap1),
    .cap_pulse(cap1_pulse)
  );

  tcw_watchdog #(
    .CNT_W(CNT_W)
  ) u_wd (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .tick(tmr_tick),
    .en_wr(wr_acc & hit(paddr, ADDR_WD_CTRL) & pwdata[WD_EN_BIT]),
    .key_wr(wr_acc & hit(paddr, ADDR_WD_KEY)),
    .key_data(pwdata[15:0]),
    .preload(st_reg.preload),
    .count(wd_count),
    .enabled(wd_enabled),
    .expired(wd_expired),
    .expire_pulse(wd_exp_pulse)
  );

  // Held until reset; the system reset controller acts on it
  assign wd_reset_req = wd_expired;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      ADDR_CAP_CFG: begin
        // Reserved bits read zero
        rd_val = (zext3(st_reg.sel1) << SEL1_LSB) | (zext3(st_reg.sel0) << SEL0_LSB);
      end
      ADDR_WD_CTRL: rd_val[WD_EN_BIT] = wd_enabled;
      ADDR_WD_PRLD: rd_val[CNT_W-1:0] = st_reg.preload;
      ADDR_WD_STAT: begin
        rd_val[ST_DIG_BIT] = wd_expired;
        rd_val[ST_ANA_BIT] = analog_wd_flag;
        rd_val[ST_ENA_BIT] = wd_enabled;
      end
      ADDR_WD_KEY: rd_val = 32'h0000_0000;
      ADDR_WD_CNTR: rd_val[CNT_W-1:0] = wd_count;
      ADDR_CAP0_FRC: rd_val = cap0.frc;
      ADDR_CAP0_UC: rd_val = cap0.uc;
      ADDR_CAP1_FRC: rd_val = cap1.frc;
      ADDR_CAP1_UC: rd_val = cap1.uc;
      ADDR_IRQ_STAT: rd_val[IRQ_W-1:0] = st_reg.irq_stat;
      ADDR_IRQ_CLR: rd_val = 32'h0000_0000;
      ADDR_IRQ_EN: rd_val[IRQ_W-1:0] = st_reg.irq_en;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_CAP0] = cap0_pulse;
    irq_set[IRQ_CAP1] = cap1_pulse;
    irq_set[IRQ_WD] = wd_exp_pulse;
    irq_clr = '0;
    if (wr_acc && hit(paddr, ADDR_IRQ_CLR)) begin
      irq_clr = pwdata[IRQ_W-1:0];
    end
  end

  always_comb begin
    st_next = st_reg;
    // Set wins over a clear in the same cycle
    st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_set;
    if (setup_ph) begin
      // Sampled at setup so the access cycle can finish at once
      st_next.rdata = pwrite ? 32'h0000_0000 : rd_val;
      st_next.slverr = ~rd_hit;
    end
    if (wr_acc) begin
      case (paddr)
        ADDR_CAP_CFG: begin
          st_next.sel0 = pwdata[SEL0_LSB +: SEL_W];
          st_next.sel1 = pwdata[SEL1_LSB +: SEL_W];
        end
        ADDR_WD_PRLD: st_next.preload = pwdata[CNT_W-1:0];
        ADDR_IRQ_EN: st_next.irq_en = pwdata[IRQ_W-1:0];
        default: st_next.preload = st_reg.preload;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg.sel0 <= SEL_RST;
      st_reg.sel1 <= SEL_RST;
      st_reg.preload <= WD_PRLD_RST[CNT_W-1:0];
      st_reg.irq_stat <= IRQ_RST;
      st_reg.irq_en <= IRQ_RST;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.slverr <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pslverr = st_reg.slverr;
  assign irq = |(st_reg.irq_stat & st_reg.irq_en);

endmodule
`default_nettype wire

// *** tcw_pkg.sv ***
// Purpose: Shared constants and types for the capture select and watchdog block
// Assumes: 32-bit APB, one clock
// Notes: Offsets are byte addresses
package tcw_pkg;

  localparam logic [31:0] ADDR_CAP_CFG = 32'h4000_0014;
  localparam logic [31:0] ADDR_WD_CTRL = 32'h4200_0090;
  localparam logic [31:0] ADDR_WD_PRLD = 32'h4200_0094;
  localparam logic [31:0] ADDR_WD_STAT = 32'h4200_0098;
  localparam logic [31:0] ADDR_WD_KEY = 32'h4200_009C;
  localparam logic [31:0] ADDR_WD_CNTR = 32'h4200_00A0;
  localparam logic [31:0] ADDR_CAP0_FRC = 32'h4200_0100;
  localparam logic [31:0] ADDR_CAP0_UC = 32'h4200_0104;
  localparam logic [31:0] ADDR_CAP1_FRC = 32'h4200_0108;
  localparam logic [31:0] ADDR_CAP1_UC = 32'h4200_010C;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h4200_0110;
  localparam logic [31:0] ADDR_IRQ_CLR = 32'h4200_0114;
  localparam logic [31:0] ADDR_IRQ_EN = 32'h4200_0118;

  localparam int SEL_W = 3;
  localparam int SEL0_LSB = 0;
  localparam int SEL1_LSB = 4;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam int NUM_EVT = 6;

  localparam int WD_EN_BIT = 0;
  localparam int ST_DIG_BIT = 0;
  localparam int ST_ANA_BIT = 1;
  localparam int ST_ENA_BIT = 2;
  localparam logic [15:0] KEY_FIRST = 16'hE51A;
  localparam logic [15:0] KEY_SECOND = 16'hA35C;
  localparam logic [31:0] WD_PRLD_RST = 32'h0000_FFFF;

  localparam int IRQ_W = 3;
  localparam int IRQ_CAP0 = 0;
  localparam int IRQ_CAP1 = 1;
  localparam int IRQ_WD = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  typedef enum logic [2:0] {
    EVT_P0_TX = 3'b000,
    EVT_P0_RX = 3'b001,
    EVT_P1_TX = 3'b010,
    EVT_P1_RX = 3'b011,
    EVT_P2_TX = 3'b100,
    EVT_P2_RX = 3'b101
  } tcw_evt_e;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ARMED = 2'b01
  } tcw_key_e;

  typedef struct packed {
    logic [31:0] frc;
    logic [31:0] uc;
  } tcw_cap_s;

endpackage

// *** tcw_capture_sel.sv ***
// Purpose: Picks one DMA event, detects its rising edge, latches counters
// Assumes: Events synchronous to ref_clk
// Notes: Undefined select codes choose no event
`timescale 1ns/10ps
`default_nettype none
module tcw_capture_sel import tcw_pkg::*; #(
  parameter int N_EVT = NUM_EVT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [N_EVT-1:0] dma_evt,
  input wire logic [SEL_W-1:0] sel,
  input wire tcw_cap_s now_cnt,
  output tcw_cap_s cap,
  output logic cap_pulse
);

  typedef struct packed {
    logic prev;
    tcw_cap_s cap;
  } tcw_csel_s;

  tcw_csel_s st_reg;
  tcw_csel_s st_next;
  logic evt_lvl;
  logic edge_hit;

  always_comb begin
    evt_lvl = 1'b0;
    case (sel)
      EVT_P0_TX: evt_lvl = dma_evt[0];
      EVT_P0_RX: evt_lvl = dma_evt[1];
      EVT_P1_TX: evt_lvl = dma_evt[2];
      EVT_P1_RX: evt_lvl = dma_evt[3];
      EVT_P2_TX: evt_lvl = dma_evt[4];
      EVT_P2_RX: evt_lvl = dma_evt[5];
      default: evt_lvl = 1'b0;
    endcase
    edge_hit = evt_lvl & ~st_reg.prev;
    st_next = st_reg;
    st_next.prev = evt_lvl;
    if (edge_hit) begin
      st_next.cap = now_cnt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign cap = st_reg.cap;
  assign cap_pulse = edge_hit & ce;

endmodule
`default_nettype wire

// *** tcw_watchdog.sv ***
// Purpose: Digital watchdog with two-word key and down-counter
// Assumes: tick marks one timer clock period
// Notes: Once enabled it cannot be turned off short of reset
`timescale 1ns/10ps
`default_nettype none
module tcw_watchdog import tcw_pkg::*; #(
  parameter int CNT_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tick,
  input wire logic en_wr,
  input wire logic key_wr,
  input wire logic [15:0] key_data,
  input wire logic [CNT_W-1:0] preload,
  output logic [CNT_W-1:0] count,
  output logic enabled,
  output logic expired,
  output logic expire_pulse
);

  typedef struct packed {
    logic en;
    tcw_key_e key_st;
    logic [CNT_W-1:0] cnt;
    logic exp;
  } tcw_wd_s;

  tcw_wd_s st_reg;
  tcw_wd_s st_next;
  logic serviced;

  always_comb begin
    st_next = st_reg;
    serviced = 1'b0;
    if (key_wr) begin
      case (st_reg.key_st)
        KEY_IDLE: st_next.key_st = (key_data == KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
        KEY_ARMED: begin
          serviced = (key_data == KEY_SECOND);
          st_next.key_st = (key_data == KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
        end
        default: st_next.key_st = KEY_IDLE;
      endcase
    end
    if (en_wr && !st_reg.en) begin
      st_next.en = 1'b1;
      st_next.cnt = preload;
    end else if (st_reg.en && !st_reg.exp) begin
      if (serviced) begin
        st_next.cnt = preload;
      end else if (tick) begin
        if (st_reg.cnt == '0) begin
          st_next.exp = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '{en: 1'b0, key_st: KEY_IDLE, cnt: '0, exp: 1'b0};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.cnt;
  assign enabled = st_reg.en;
  assign expired = st_reg.exp;
  assign expire_pulse = ce & st_next.exp & ~st_reg.exp;

endmodule
`default_nettype wire

// *** tcw_assertions.sv ***
// Purpose: Port checks for capture select and watchdog
// Assumes: One clock, bound to the top module
// Notes: Read data loads at the setup edge
`timescale 1ns/10ps
`default_nettype none
module tcw_assertions import tcw_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic analog_wd_flag,
  input wire logic wd_reset_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic su = psel && !penable && ce;
  wire logic rd = su && !pwrite;
  AST_RDY: assert property (pready == ce) else $error("pready");
  AST_WDOFF: assert property ($fell(rst) |-> !wd_reset_req) else $error("wd off");
  AST_WDHOLD: assert property (wd_reset_req |=> wd_reset_req) else $error("wd hold");
  AST_CFGRSV: assert property (rd && paddr == ADDR_CAP_CFG |=> prdata[31:7] == 0 && !prdata[3] && !pslverr)
    else $error("cfg read");
  AST_KEYWO: assert property (rd && paddr == ADDR_WD_KEY |=> prdata == 0) else $error("key read");
  AST_STAT: assert property (rd && paddr == ADDR_WD_STAT |=>
    prdata[ST_ANA_BIT] == $past(analog_wd_flag) && prdata[ST_DIG_BIT] == $past(wd_reset_req))
    else $error("status");
  AST_HOLD: assert property (!su |=> $stable(prdata) && $stable(pslverr)) else $error("hold");
  AST_CTRLEN: assert property (rd && paddr == ADDR_WD_CTRL && wd_reset_req |=> prdata[WD_EN_BIT])
    else $error("enable");
endmodule
`default_nettype wire

// *** tcw_evt_src.sv ***
// Purpose: DMA event lines of three audio ports
// Assumes: Fire requests come on clock edges
// Notes: Slow mode stretches a level to three cycles
`timescale 1ns/10ps
`default_nettype none
module tcw_evt_src (
  input wire logic ref_clk,
  input wire logic [5:0] fire,
  input wire logic slow,
  output logic [5:0] dma_evt
);
  logic [5:0] d1;
  logic [5:0] d2;
  always_ff @(posedge ref_clk) begin
    d1 <= fire;
    d2 <= d1;
    dma_evt <= fire | d1 | (slow ? d2 : 6'h00);
  end
endmodule
`default_nettype wire

// *** tb_tcw_timer_capture_select_watchdog.sv ***
// Purpose: Self-checking bench for capture select and watchdog
// Assumes: APB master waits for pready
// Notes: Small preload so expiry comes fast
`timescale 1ns/10ps
`default_nettype none
module tb_tcw_timer_capture_select_watchdog import tcw_pkg::*;;
  logic ref_clk, rst, ce, psel, penable, pwrite, tmr_tick, analog_wd_flag, slow, rerr;
  logic pready, pslverr, wd_reset_req, irq;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [5:0] dma_evt, fire;
  logic [2:0] s0, s1;
  tcw_cap_s cnt0_now, cnt1_now;
  int mismatches = 0;
  int check_count = 0;
  tcw_timer_capture_select_watchdog uut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dma_evt(dma_evt), .tmr_tick(tmr_tick), .cnt0_now(cnt0_now),
    .cnt1_now(cnt1_now), .analog_wd_flag(analog_wd_flag), .wd_reset_req(wd_reset_req), .irq(irq));
  tcw_evt_src u_evt (.ref_clk(ref_clk), .fire(fire), .slow(slow), .dma_evt(dma_evt));
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the bench watchdog ends a stalled transfer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(nm, e, rdat);
  endtask
  task tick(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      tmr_tick <= 1'b1;
      @(posedge ref_clk);
      tmr_tick <= 1'b0;
    end
  endtask
  task shot(input logic [5:0] f);
    fire <= f;
    @(posedge ref_clk);
    fire <= 6'h00;
    repeat (4) @(posedge ref_clk);
  endtask
  function logic [31:0] cfgv(input logic [2:0] a, input logic [2:0] b);
    return {25'h000_0000, b, 1'b0, a};
  endfunction
  initial begin
    #400000;
    mismatches++;
    conclude();
  end
  initial begin
    rst = 1;
    ce = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    tmr_tick = 0;
    analog_wd_flag = 0;
    fire = 0;
    slow = 0;
    cnt0_now = '0;
    cnt1_now = '0;
    void'($urandom(46198));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rdc("cfg", ADDR_CAP_CFG, 32'h0);
    rdc("ctrl", ADDR_WD_CTRL, 32'h0);
    rdc("prld", ADDR_WD_PRLD, WD_PRLD_RST);
    rdc("hole", 32'h4200_0080, 32'h0);
    cmp("err", 32'h1, {31'h0, rerr});
    for (int i = 0; i < 8; i++) begin
      s0 = 3'($urandom_range(5));
      s1 = 3'($urandom_range(5));
      apb(1'b1, ADDR_CAP_CFG, cfgv(s0, s1));
      rdc("cfg", ADDR_CAP_CFG, cfgv(s0, s1));
    end
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, ADDR_CAP_CFG, cfgv(3'(k), 3'(5 - k)));
      cnt0_now <= {$urandom, $urandom};
      slow <= k[0];
      shot(6'h01 << k);
      rdc("frc0", ADDR_CAP0_FRC, cnt0_now.frc);
      rdc("uc0", ADDR_CAP0_UC, cnt0_now.uc);
      rdc("ist", ADDR_IRQ_STAT, 32'h1);
      cmp("irq", 32'h1, {31'h0, irq});
      apb(1'b1, ADDR_IRQ_CLR, 32'h7);
    end
    apb(1'b1, ADDR_IRQ_EN, 32'h0);
    cnt1_now <= {$urandom, $urandom};
    shot(6'h01);
    rdc("uc1", ADDR_CAP1_UC, cnt1_now.uc);
    rdc("ist", ADDR_IRQ_STAT, 32'h2);
    cmp("irq", 32'h0, {31'h0, irq});
    apb(1'b1, ADDR_IRQ_CLR, 32'h7);
    analog_wd_flag <= 1'b1;
    apb(1'b1, ADDR_WD_PRLD, 32'h5);
    apb(1'b1, ADDR_WD_CTRL, 32'h1);
    rdc("cnt", ADDR_WD_CNTR, 32'h5);
    rdc("st", ADDR_WD_STAT, 32'h6);
    tick(3);
    rdc("cnt", ADDR_WD_CNTR, 32'h2);
    apb(1'b1, ADDR_WD_KEY, {16'h0, KEY_FIRST});
    apb(1'b1, ADDR_WD_KEY, {16'h0, KEY_SECOND});
    rdc("cnt", ADDR_WD_CNTR, 32'h5);
    tick(2);
    apb(1'b1, ADDR_WD_KEY, {16'h0, KEY_FIRST});
    apb(1'b1, ADDR_WD_KEY, 32'h1234);
    apb(1'b1, ADDR_WD_KEY, {16'h0, KEY_SECOND});
    rdc("cnt", ADDR_WD_CNTR, 32'h3);
    // Ticks while ce is low must not move the count
    ce <= 1'b0;
    tick(2);
    ce <= 1'b1;
    rdc("frz", ADDR_WD_CNTR, 32'h3);
    tick(3);
    @(posedge ref_clk);
    cmp("wdr", 32'h0, {31'h0, wd_reset_req});
    tick(1);
    // Expiry lands at the tick edge; look one edge later
    @(posedge ref_clk);
    cmp("wdr", 32'h1, {31'h0, wd_reset_req});
    rdc("st", ADDR_WD_STAT, 32'h7);
    rdc("ctrl", ADDR_WD_CTRL, 32'h1);
    rdc("key", ADDR_WD_KEY, 32'h0);
    rdc("ist", ADDR_IRQ_STAT, 32'h4);
    conclude();
  end
endmodule
bind tcw_timer_capture_select_watchdog tcw_assertions u_ast (.ref_clk(ref_clk), .rst(rst), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .analog_wd_flag(analog_wd_flag), .wd_reset_req(wd_reset_req));
`default_nettype wire
